// file: rtl/nmic_ctrl.v
// Interrupt controller with entry and return sequencing for the core
`timescale 1ns/1ps
`include "nmic_defines.vh"

// Notes on behaviour
// R1 - Same level ties go to lowest default index
// R2 - Code and vector are 0080H plus index*10H
// R3 - Divide in progress saves its own address
// R4 - Illegal opcode address is saved PC minus 4
// R5 - NMI ignores disable and beats all maskables
// R6 - NMI edge chosen by rise and fall enables
// R7 - NMI waits while NMI service is active
// R8 - Extra NMIs collapse into one pending
// R9 - NMI entry saves state, code 0010H, vector 10H
// R10 - Return with EP 0, NP 1 restores NMI state
// R11 - Software sets EP 0, NP 1 before return
// R12 - NMI service blocks all interrupts and exceptions
// R13 - Ninety maskable sources, each maskable
// R14 - Eight programmable levels dominate default order
// R15 - Maskable accept sets interrupt disable
// R16 - Only strictly higher level may nest
// R17 - Software saves state before nesting, restores disabled
// R18 - Maskable entry saves state, code, jumps to vector
// R19 - Masked or blocked requests stay pending
// R20 - Return with EP 0, NP 0 restores maskable state
// R21 - Control register bit 6 masks, resets to 47H
// R22 - Priority field value equals level, 0 highest
// R23 - NMI pin synchronised, edge sets pending flag
module nmic_ctrl (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire [`NMIC_NUM_SRC-1:0] i_irq_src,
    input wire i_ctl_wr,
    input wire [`NMIC_IDX_W-1:0] i_ctl_sel,
    input wire [7:0] i_ctl_wdata,
    output wire [7:0] o_ctl_rdata,
    input wire i_nmi_pin,
    input wire i_nmi_rise_enable,
    input wire i_nmi_fall_enable,
    input wire i_boundary,
    input wire [31:0] i_cur_pc,
    input wire [31:0] i_next_pc,
    input wire i_div_busy,
    input wire i_ilgop,
    input wire i_return_from_interrupt,
    input wire i_ei,
    input wire i_di,
    input wire i_sr_wr,
    input wire [2:0] i_sr_sel,
    input wire [31:0] i_sr_wdata,
    output wire o_redirect,
    output wire [31:0] o_redirect_pc,
    output wire [31:0] o_psw,
    output wire [31:0] o_nmi_saved_pc,
    output wire [31:0] o_nmi_saved_status,
    output wire [31:0] o_int_saved_pc,
    output wire [31:0] o_int_saved_status,
    output wire [31:0] o_exception_cause,
    output wire o_nmi_pending,
    output wire [7:0] o_in_service
);

    // ****************************************
    // Declarations
    // ****************************************
    reg [31:0] psw_r;
    reg [31:0] psw_nxt;
    reg [31:0] nmi_pc_r;
    reg [31:0] nmi_pc_nxt;
    reg [31:0] nmi_st_r;
    reg [31:0] nmi_st_nxt;
    reg [31:0] int_pc_r;
    reg [31:0] int_pc_nxt;
    reg [31:0] int_st_r;
    reg [31:0] int_st_nxt;
    reg [31:0] cause_r;
    reg [31:0] cause_nxt;
    reg [7:0] ispr_r;
    reg [7:0] ispr_nxt;
    reg redir_r;
    reg redir_nxt;
    reg [31:0] redir_pc_r;
    reg [31:0] redir_pc_nxt;
    reg [7:0] rdata_r;
    reg nmi_s1_r;
    reg nmi_s2_r;
    reg nmi_s3_r;
    reg nmi_pend_r;
    wire nmi_rise;
    wire nmi_fall;
    wire nmi_edge;
    wire [8*`NMIC_NUM_SRC-1:0] ctl_all;
    wire [31:0] ret_pc;
    wire np;
    wire ep;
    wire id;
    reg best_found;
    reg [2:0] best_lvl;
    reg [`NMIC_IDX_W-1:0] best_idx;
    reg [2:0] min_lvl;
    wire nest_ok;
    wire take_nmi;
    wire take_ilg;
    wire take_mi;
    wire [15:0] mi_code;
    integer i;
    integer j;
    genvar g;

    assign np = psw_r[`NMIC_PSW_NP];
    assign ep = psw_r[`NMIC_PSW_EP];
    assign id = psw_r[`NMIC_PSW_ID];

    // ****************************************
    // Maskable sources
    // ****************************************
    generate
        for (g = 0; g < `NMIC_NUM_SRC; g = g + 1) begin : gen_src
            nmic_src u_src (
                .i_core_clk(i_core_clk),
                .i_rst_n(i_rst_n),
                .i_req(i_irq_src[g]),
                .i_wr(i_ctl_wr && (i_ctl_sel == g)),
                .i_wdata(i_ctl_wdata),
                .i_ack(take_mi && (best_idx == g)),
                .o_ctl(ctl_all[8*g +: 8])
            ); // R13
        end
    endgenerate

    // Registered read of the selected control register
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rdata_r <= 8'h00;
        end else if (i_ctl_sel < `NMIC_NUM_SRC) begin
            rdata_r <= ctl_all[8*i_ctl_sel +: 8];
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // ****************************************
    // Arbitration
    // ****************************************
    // Strict compare keeps the lower index on equal levels
    always @* begin
        best_found = 1'b0;
        best_lvl = `NMIC_LVL_LOWEST;
        best_idx = {`NMIC_IDX_W{1'b0}};
        for (i = 0; i < `NMIC_NUM_SRC; i = i + 1) begin
            if (ctl_all[8*i+`NMIC_CTL_IF] && !ctl_all[8*i+`NMIC_CTL_MK] && // R19
                (!best_found || (ctl_all[8*i +: 3] < best_lvl))) begin // R14
                best_found = 1'b1;
                best_lvl = ctl_all[8*i +: 3];
                best_idx = i[`NMIC_IDX_W-1:0]; // R1
            end
        end
    end

    // Highest level currently in service
    always @* begin
        min_lvl = `NMIC_LVL_LOWEST;
        for (j = 7; j >= 0; j = j - 1) begin
            if (ispr_r[j]) begin
                min_lvl = j[2:0];
            end
        end
    end

    assign nest_ok = (ispr_r == 8'h00) || (best_lvl < min_lvl); // R16

    // ****************************************
    // NMI edge detection
    // ****************************************
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            nmi_s1_r <= 1'b0;
            nmi_s2_r <= 1'b0;
            nmi_s3_r <= 1'b0;
        end else begin
            nmi_s1_r <= i_nmi_pin; // R23
            nmi_s2_r <= nmi_s1_r;
            nmi_s3_r <= nmi_s2_r;
        end
    end

    assign nmi_rise = nmi_s2_r & ~nmi_s3_r;
    assign nmi_fall = ~nmi_s2_r & nmi_s3_r;
    assign nmi_edge = (nmi_rise & i_nmi_rise_enable) | (nmi_fall & i_nmi_fall_enable); // R6

    // One flag, so repeated edges merge; a new edge wins over accept
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            nmi_pend_r <= 1'b0;
        end else begin
            nmi_pend_r <= nmi_edge | (nmi_pend_r & ~take_nmi); // R8 R23
        end
    end

    // ****************************************
    // Acceptance
    // ****************************************
    assign take_nmi = i_boundary && !i_return_from_interrupt && nmi_pend_r && !np; // R5 R7
    assign take_ilg = i_boundary && !i_return_from_interrupt && !take_nmi && i_ilgop && !np; // R12
    assign take_mi = i_boundary && !i_return_from_interrupt && !take_nmi && !i_ilgop &&
                     best_found && !id && !np && nest_ok; // R12 R15 R19
    assign ret_pc = i_div_busy ? i_cur_pc : i_next_pc; // R3
    assign mi_code = `NMIC_MI_CODE_BASE + {5'h00, best_idx, 4'h0}; // R2

    // ****************************************
    // Status word, saved context and cause
    // ****************************************
    always @* begin
        psw_nxt = psw_r;
        nmi_pc_nxt = nmi_pc_r;
        nmi_st_nxt = nmi_st_r;
        int_pc_nxt = int_pc_r;
        int_st_nxt = int_st_r;
        cause_nxt = cause_r;
        ispr_nxt = ispr_r;
        redir_nxt = 1'b0;
        redir_pc_nxt = redir_pc_r;
        if (i_sr_wr) begin
            case (i_sr_sel)
                `NMIC_SR_INT_PC: int_pc_nxt = i_sr_wdata; // R17
                `NMIC_SR_INT_ST: int_st_nxt = i_sr_wdata; // R17
                `NMIC_SR_NMI_PC: nmi_pc_nxt = i_sr_wdata;
                `NMIC_SR_NMI_ST: nmi_st_nxt = i_sr_wdata;
                `NMIC_SR_PSW: psw_nxt = i_sr_wdata; // R11
                `NMIC_SR_CAUSE: cause_nxt = i_sr_wdata;
                default: psw_nxt = psw_r;
            endcase
        end
        if (i_ei) begin
            psw_nxt[`NMIC_PSW_ID] = 1'b0;
        end
        if (i_di) begin
            psw_nxt[`NMIC_PSW_ID] = 1'b1;
        end
        if (i_return_from_interrupt) begin
            redir_nxt = 1'b1;
            if (!ep && np) begin
                redir_pc_nxt = nmi_pc_r; // R10
                psw_nxt = nmi_st_r; // R10
            end else begin
                redir_pc_nxt = int_pc_r; // R20
                psw_nxt = int_st_r; // R20
                if (!ep) begin
                    ispr_nxt[min_lvl] = 1'b0; // R16
                end
            end
        end else if (take_nmi) begin
            nmi_pc_nxt = ret_pc; // R9
            nmi_st_nxt = psw_r; // R9
            cause_nxt[31:16] = `NMIC_NMI_CODE; // R9
            psw_nxt = psw_r;
            psw_nxt[`NMIC_PSW_NP] = 1'b1; // R12
            psw_nxt[`NMIC_PSW_ID] = 1'b1; // R9
            psw_nxt[`NMIC_PSW_EP] = 1'b0; // R9
            redir_nxt = 1'b1;
            redir_pc_nxt = `NMIC_NMI_VECTOR; // R9
        end else if (take_ilg) begin
            // Restored PC is the next address, offender sits 4 below it
            int_pc_nxt = i_next_pc; // R4
            int_st_nxt = psw_r;
            cause_nxt[15:0] = `NMIC_ILG_CODE;
            psw_nxt = psw_r;
            psw_nxt[`NMIC_PSW_EP] = 1'b1;
            psw_nxt[`NMIC_PSW_ID] = 1'b1;
            redir_nxt = 1'b1;
            redir_pc_nxt = `NMIC_ILG_VECTOR;
        end else if (take_mi) begin
            int_pc_nxt = ret_pc; // R18
            int_st_nxt = psw_r; // R18
            cause_nxt[15:0] = mi_code; // R18
            psw_nxt = psw_r;
            psw_nxt[`NMIC_PSW_ID] = 1'b1; // R15
            psw_nxt[`NMIC_PSW_EP] = 1'b0; // R18
            ispr_nxt[best_lvl] = 1'b1; // R16
            redir_nxt = 1'b1;
            redir_pc_nxt = {16'h0000, mi_code}; // R2 R18
        end
    end

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            psw_r <= `NMIC_PSW_RESET;
            nmi_pc_r <= 32'h00000000;
            nmi_st_r <= 32'h00000000;
            int_pc_r <= 32'h00000000;
            int_st_r <= 32'h00000000;
            cause_r <= 32'h00000000;
            ispr_r <= 8'h00;
            redir_r <= 1'b0;
            redir_pc_r <= 32'h00000000;
        end else begin
            psw_r <= psw_nxt;
            nmi_pc_r <= nmi_pc_nxt;
            nmi_st_r <= nmi_st_nxt;
            int_pc_r <= int_pc_nxt;
            int_st_r <= int_st_nxt;
            cause_r <= cause_nxt;
            ispr_r <= ispr_nxt;
            redir_r <= redir_nxt;
            redir_pc_r <= redir_pc_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_ctl_rdata = rdata_r;
    assign o_redirect = redir_r;
    assign o_redirect_pc = redir_pc_r;
    assign o_psw = psw_r;
    assign o_nmi_saved_pc = nmi_pc_r;
    assign o_nmi_saved_status = nmi_st_r;
    assign o_int_saved_pc = int_pc_r;
    assign o_int_saved_status = int_st_r;
    assign o_exception_cause = cause_r;
    assign o_nmi_pending = nmi_pend_r;
    assign o_in_service = ispr_r;

endmodule // nmic_ctrl

// file: shared/nmic_defines.vh
// Constants for the non-maskable and maskable interrupt controller
`ifndef NMIC_DEFINES_VH
`define NMIC_DEFINES_VH

// ****************************************
// Source count and control register layout
// ****************************************
`define NMIC_NUM_SRC 90
`define NMIC_IDX_W 7
`define NMIC_CTL_RESET 8'h47
`define NMIC_CTL_IF 7
`define NMIC_CTL_MK 6
`define NMIC_LVL_LOWEST 3'h7

// ****************************************
// Status word bits and reset value
// ****************************************
`define NMIC_PSW_ID 5
`define NMIC_PSW_EP 6
`define NMIC_PSW_NP 7
`define NMIC_PSW_RESET 32'h00000020

// ****************************************
// Exception codes and handler addresses
// ****************************************
`define NMIC_NMI_CODE 16'h0010
`define NMIC_NMI_VECTOR 32'h00000010
`define NMIC_ILG_CODE 16'h0060
`define NMIC_ILG_VECTOR 32'h00000060
`define NMIC_MI_CODE_BASE 16'h0080
`define NMIC_ILG_OFFSET 32'h00000004

// ****************************************
// System register select codes
// ****************************************
`define NMIC_SR_INT_PC 3'h0
`define NMIC_SR_INT_ST 3'h1
`define NMIC_SR_NMI_PC 3'h2
`define NMIC_SR_NMI_ST 3'h3
`define NMIC_SR_PSW 3'h4
`define NMIC_SR_CAUSE 3'h5

`endif

// file: rtl/nmic_src.v
// One maskable source: request flag, mask flag and priority field
`timescale 1ns/1ps
`include "nmic_defines.vh"

module nmic_src (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire i_req,
    input wire i_wr,
    input wire [7:0] i_wdata,
    input wire i_ack,
    output wire [7:0] o_ctl
);

    reg flag_r;
    reg mask_r;
    reg [2:0] prio_r;
    wire flag_nxt;

    // ****************************************
    // Request set wins over ack and write
    // ****************************************
    assign flag_nxt = i_req | (i_wr ? i_wdata[`NMIC_CTL_IF] : (flag_r & ~i_ack)); // R19

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            flag_r <= 1'b0;
            mask_r <= 1'b1; // R21
            prio_r <= `NMIC_LVL_LOWEST;
        end else begin
            flag_r <= flag_nxt;
            if (i_wr) begin
                mask_r <= i_wdata[`NMIC_CTL_MK]; // R21
                prio_r <= i_wdata[2:0]; // R22
            end
        end
    end

    assign o_ctl = {flag_r, mask_r, 3'h0, prio_r};

endmodule // nmic_src

// file: verification/nmic_core_model.sv
// Behavioural core model: steps the PC and follows redirects
`timescale 1ns/1ps
module nmic_core_model (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire i_hold,
    input wire i_redirect,
    input wire [31:0] i_target,
    output wire o_boundary,
    output wire [31:0] o_cur_pc,
    output wire [31:0] o_next_pc
);
    reg [31:0] pc_r;
    assign o_boundary = ~i_hold;
    assign o_cur_pc = pc_r;
    assign o_next_pc = pc_r + 32'h00000004;
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pc_r <= 32'h00001000;
        end else if (i_redirect) begin
            pc_r <= i_target;
        end else if (!i_hold) begin
            pc_r <= o_next_pc;
        end
    end
endmodule // nmic_core_model

// file: verification/nmic_ctrl_monitor.sv
// Port-level assertions for the interrupt controller
`timescale 1ns/1ps
module nmic_ctrl_monitor (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire i_boundary,
    input wire i_ilgop,
    input wire i_return_from_interrupt,
    input wire i_sr_wr,
    input wire o_redirect,
    input wire [31:0] o_redirect_pc,
    input wire [31:0] o_psw,
    input wire [31:0] o_nmi_saved_pc,
    input wire [31:0] o_nmi_saved_status,
    input wire [31:0] o_int_saved_pc,
    input wire [31:0] o_exception_cause,
    input wire o_nmi_pending
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    a_nmi_entry_vec: assert property (o_redirect && $rose(o_psw[7]) |-> o_redirect_pc == 32'h10
        && o_exception_cause[31:16] == 16'h0010 && o_psw[6:5] == 2'b01) else $error("nmi entry");
    a_nmi_saved_psw: assert property (o_redirect && $rose(o_psw[7])
        |-> o_nmi_saved_status == $past(o_psw)) else $error("nmi saved status");
    a_mi_vector: assert property (o_redirect && $rose(o_psw[5]) && !o_psw[7]
        |-> o_redirect_pc == {16'h0000, o_exception_cause[15:0]} && o_redirect_pc[3:0] == 4'h0)
        else $error("vector differs from code");
    a_np_blocks: assert property (o_psw[7] && !i_return_from_interrupt && !i_sr_wr |=> !o_redirect)
        else $error("entry during nmi service");
    a_id_blocks: assert property (o_psw[5] && !o_nmi_pending && !i_ilgop && !i_return_from_interrupt
        && !i_sr_wr |=> !o_redirect) else $error("entry while disabled");
    a_nmi_first: assert property (o_nmi_pending && i_boundary && !o_psw[7] && !i_return_from_interrupt
        |=> o_redirect && o_redirect_pc == 32'h10) else $error("nmi not taken");
    a_return_from_interrupt_nmi: assert property (i_return_from_interrupt && !i_sr_wr && o_psw[7:6] == 2'b10 |=> o_redirect
        && o_redirect_pc == $past(o_nmi_saved_pc) && o_psw == $past(o_nmi_saved_status))
        else $error("nmi return");
    a_return_from_interrupt_int: assert property (i_return_from_interrupt && !i_sr_wr && o_psw[7:6] == 2'b00 |=> o_redirect
        && o_redirect_pc == $past(o_int_saved_pc)) else $error("maskable return");
    a_nmi_pend_hold: assert property (o_nmi_pending && (o_psw[7] || !i_boundary)
        |=> o_nmi_pending) else $error("nmi pending lost");
endmodule // nmic_ctrl_monitor
bind nmic_ctrl nmic_ctrl_monitor nmic_ctrl_monitor_inst (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_boundary(i_boundary), .i_ilgop(i_ilgop), .i_return_from_interrupt(i_return_from_interrupt),
    .i_sr_wr(i_sr_wr), .o_redirect(o_redirect), .o_redirect_pc(o_redirect_pc), .o_psw(o_psw),
    .o_nmi_saved_pc(o_nmi_saved_pc), .o_nmi_saved_status(o_nmi_saved_status),
    .o_int_saved_pc(o_int_saved_pc), .o_exception_cause(o_exception_cause),
    .o_nmi_pending(o_nmi_pending));

// file: verification/nmic_ctrl_test.sv
// Self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`include "nmic_defines.vh"
module nmic_ctrl_test;
    reg i_core_clk = 1'b0;
    reg i_rst_n = 1'b0;
    reg [`NMIC_NUM_SRC-1:0] irq = '0;
    reg ctl_wr = 1'b0;
    reg [`NMIC_IDX_W-1:0] ctl_sel = '0;
    reg [7:0] ctl_wdata = 8'h00;
    reg nmi_pin = 1'b0;
    reg rise_en = 1'b0;
    reg fall_en = 1'b0;
    reg div_busy = 1'b0;
    reg ilgop = 1'b0;
    reg return_from_interrupt = 1'b0;
    reg ei = 1'b0;
    reg di = 1'b0;
    reg hold = 1'b1;
    reg sr_wr = 1'b0;
    reg [2:0] sr_sel = 3'h0;
    reg [31:0] sr_wdata = 32'h00000000;
    wire boundary, redirect, nmi_pend;
    wire [31:0] cur_pc, next_pc, rpc, program_status_word, nmi_spc, nmi_sst, int_spc, int_sst, cause;
    wire [7:0] ctl_rdata;
    wire [7:0] isr;
    integer mismatches = 0;
    integer samples_checked = 0;
    integer i;
    reg [31:0] snap;
    always #10 i_core_clk = ~i_core_clk;
    nmic_ctrl nmic_ctrl_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_irq_src(irq),
        .i_ctl_wr(ctl_wr), .i_ctl_sel(ctl_sel), .i_ctl_wdata(ctl_wdata), .o_ctl_rdata(ctl_rdata),
        .i_nmi_pin(nmi_pin), .i_nmi_rise_enable(rise_en), .i_nmi_fall_enable(fall_en),
        .i_boundary(boundary), .i_cur_pc(cur_pc), .i_next_pc(next_pc), .i_div_busy(div_busy),
        .i_ilgop(ilgop), .i_return_from_interrupt(return_from_interrupt), .i_ei(ei), .i_di(di), .i_sr_wr(sr_wr), .i_sr_sel(sr_sel),
        .i_sr_wdata(sr_wdata), .o_redirect(redirect), .o_redirect_pc(rpc), .o_psw(program_status_word),
        .o_nmi_saved_pc(nmi_spc), .o_nmi_saved_status(nmi_sst), .o_int_saved_pc(int_spc),
        .o_int_saved_status(int_sst), .o_exception_cause(cause), .o_nmi_pending(nmi_pend),
        .o_in_service(isr));
    nmic_core_model nmic_core_model_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_hold(hold), .i_redirect(redirect), .i_target(rpc), .o_boundary(boundary),
        .o_cur_pc(cur_pc), .o_next_pc(next_pc));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task waitr;
        integer k;
        begin
            @(posedge i_core_clk);
            for (k = 0; k < 12 && redirect !== 1'b1; k = k + 1)
                @(posedge i_core_clk);
            chk({31'h0, redirect}, 32'h1);
        end
    endtask
    task take(input [31:0] exp);
        begin
            @(posedge i_core_clk);
            snap = cur_pc;
            hold <= 1'b0;
            waitr;
            hold <= 1'b1;
            chk(rpc, exp);
        end
    endtask
    task quiet;
        begin
            hold <= 1'b0;
            repeat (6) begin
                @(posedge i_core_clk);
                chk({31'h0, redirect}, 32'h0);
            end
            hold <= 1'b1;
        end
    endtask
    task ret;
        begin
            @(posedge i_core_clk) return_from_interrupt <= 1'b1;
            @(posedge i_core_clk) return_from_interrupt <= 1'b0;
            waitr;
        end
    endtask
    task pulse_en(input on);
        begin
            @(posedge i_core_clk) begin ei <= on; di <= !on; end
            @(posedge i_core_clk) begin ei <= 1'b0; di <= 1'b0; end
        end
    endtask
    task wc(input [6:0] s, input [7:0] d);
        begin
            @(posedge i_core_clk) begin ctl_wr <= 1'b1; ctl_sel <= s; ctl_wdata <= d; end
            @(posedge i_core_clk) ctl_wr <= 1'b0;
        end
    endtask
    task wsr(input [2:0] s, input [31:0] d);
        begin
            @(posedge i_core_clk) begin sr_wr <= 1'b1; sr_sel <= s; sr_wdata <= d; end
            @(posedge i_core_clk) sr_wr <= 1'b0;
        end
    endtask
    task rc(input [6:0] s, input [7:0] exp);
        begin
            @(posedge i_core_clk) ctl_sel <= s;
            repeat (3) @(posedge i_core_clk);
            chk({24'h0, ctl_rdata}, {24'h0, exp});
        end
    endtask
    task wp;
        integer k;
        begin
            for (k = 0; k < 10 && nmi_pend !== 1'b1; k = k + 1)
                @(posedge i_core_clk);
            chk({31'h0, nmi_pend}, 32'h1);
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        repeat (3000) @(posedge i_core_clk);
        mismatches = mismatches + 1;
        results;
    end
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        rc(7'd83, 8'h47);
        rc(7'd95, 8'h00);
        div_busy <= 1'b1;
        wc(7'd5, 8'h03);
        wc(7'd10, 8'h00);
        wc(7'd83, 8'h00);
        @(posedge i_core_clk) begin irq[5] <= 1'b1; irq[10] <= 1'b1; irq[83] <= 1'b1; end
        @(posedge i_core_clk) irq <= '0;
        pulse_en(1'b1);
        take(32'h00000120);
        chk(int_spc, snap);
        chk({16'h0, cause[15:0]}, 32'h00000120);
        chk(program_status_word, 32'h00000020);
        chk(int_sst, 32'h00000000);
        chk({24'h0, isr}, 32'h00000001);
        $display("test priority done");
        div_busy <= 1'b0;
        pulse_en(1'b1);
        quiet;
        pulse_en(1'b0);
        ret;
        chk(rpc, snap);
        take(32'h000005b0);
        chk(int_spc, snap + 32'h4);
        $display("test nesting done");
        @(posedge i_core_clk) begin rise_en <= 1'b1; nmi_pin <= 1'b1; end
        wp;
        take(32'h00000010);
        chk(nmi_sst, 32'h00000020);
        chk(program_status_word, 32'h000000a0);
        chk(nmi_spc, snap + 32'h4);
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge i_core_clk) nmi_pin <= 1'b0;
            repeat (4) @(posedge i_core_clk);
            nmi_pin <= 1'b1;
            repeat (4) @(posedge i_core_clk);
        end
        wp;
        quiet;
        ret;
        chk(rpc, snap + 32'h4);
        chk(program_status_word, 32'h00000020);
        take(32'h00000010);
        repeat (2) @(posedge i_core_clk);
        chk({31'h0, nmi_pend}, 32'h0);
        wsr(3'h4, 32'h000000e0);
        wsr(3'h4, 32'h000000a0);
        @(posedge i_core_clk);
        chk(program_status_word, 32'h000000a0);
        ret;
        chk(rpc, snap + 32'h4);
        $display("test nmi done");
        @(posedge i_core_clk);
        snap = cur_pc;
        ilgop <= 1'b1;
        hold <= 1'b0;
        @(posedge i_core_clk) ilgop <= 1'b0;
        waitr;
        hold <= 1'b1;
        chk(rpc, 32'h00000060);
        chk(int_spc - 32'h4, snap);
        @(posedge i_core_clk) begin rise_en <= 1'b0; fall_en <= 1'b1; nmi_pin <= 1'b0; end
        wp;
        $display("test edges done");
        results;
    end
endmodule // nmic_ctrl_test
